// >>> hdl/lrt_core.sv
// Resonance tracking and open-loop fallback core of a haptic driver.
// Assumes a byte register port fed by the serial register interface,
// synchronous inputs, and a zero-cross pulse from the back-EMF comparator.
`timescale 1ns/1ns

// Functional notes
// RULE_01 - Software sets the actuator type bit before it starts a waveform.
// RULE_02 - The drive phase locks to resonance at the first back-EMF zero cross.
// RULE_03 - Every later zero cross re-times the drive, following drift.
// RULE_04 - Tracking needs no calibration and level calibration never touches it.
// RULE_05 - The tracked resonance period is readable at register 0x22.
// RULE_06 - Software reads the period only while driving a moving actuator.
// RULE_07 - Without valid back-EMF the drive continues open-loop at a default rate.
// RULE_08 - The default half period is drive time minus zero-cross detect time.
// RULE_09 - When back-EMF becomes valid again the tracker takes over once more.
// RULE_10 - With auto open-loop enabled the open-loop state never resynchronises.
// RULE_11 - Auto open-loop is entered only after cycles that failed to sync.
// RULE_12 - A two-bit field sets how many unsynced cycles are tolerated.
// RULE_13 - Open-loop period is the seven-bit period field times the unit.
// RULE_14 - In auto open-loop, overdrive and braking are disabled.
// RULE_15 - The output is trinary: positive, negative or off.
// RULE_16 - The unsynced cycle counter clears when a new waveform starts.
module lrt_core
  import lrt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic [7:0] REG_RDATA,
  input wire logic GO,
  input wire logic BEMF_VALID,
  input wire logic ZERO_CROSS,
  input wire logic [4:0] DRIVE_TIME,
  input wire logic [1:0] ZERO_CROSS_DETECT_TIME,
  input wire logic [6:0] OPEN_LOOP_PERIOD,
  output logic DRIVE_POS,
  output logic DRIVE_NEG,
  output logic CLOSED_LOOP_ACTIVE,
  output logic SYNCED
);
  import lrt_pkg::*;

  lrt_tick_if tick_bus ();
  logic [7:0] actuator_config;
  logic [7:0] open_loop_fallback_config;
  logic [7:0] resonance_period_report;
  lrt_state_t state;
  lrt_state_t next_state;
  logic go_d;
  logic [7:0] half_count;
  logic [7:0] default_half;
  logic [7:0] ol_half;
  logic [2:0] miss_count;
  logic [2:0] miss_limit;
  logic polarity;
  logic actuator_type_select;
  logic auto_open_loop_enable;
  logic start;
  logic tick;
  logic zc_hit;
  logic timeout;
  logic ol_flip;
  logic miss_due;

  lrt_tick u_tick
  (
    .CLK(CLK),
    .RST_B(RST_B),
    .TICK(tick_bus.source)
  );

  assign tick = tick_bus.tick;
  assign actuator_type_select = actuator_config[ACTUATOR_TYPE_SELECT_BIT];
  assign auto_open_loop_enable =
    open_loop_fallback_config[AUTO_OPEN_LOOP_ENABLE_BIT];
  // Tolerated unsynced cycles is the field value plus one.
  assign miss_limit = {1'b0,
    open_loop_fallback_config[OPEN_LOOP_FALLBACK_COUNT_LSB +: 2]} + 3'd1;
  assign start = GO && !go_d;

  // Default half period from drive and detect times, never below one unit.
  always_comb
  begin
    logic [5:0] zc_units;
    zc_units = {4'h0, ZERO_CROSS_DETECT_TIME} + 6'd1;
    if ({1'b0, DRIVE_TIME} > zc_units)
      default_half = {2'b00, 6'({1'b0, DRIVE_TIME} - zc_units)}; // [RULE_08]
    else
      default_half = 8'h01;
  end

  // Open-loop half period in units; the full cycle spans the period field.
  assign ol_half = {1'b0, OPEN_LOOP_PERIOD} >> 1;

  // Event terms; tracking uses only zero crosses, no calibration data.
  assign zc_hit = ZERO_CROSS && BEMF_VALID && actuator_type_select; // [RULE_04]
  // The timer counts whole units, so the flip lands on the tick that ends
  // the default half period.
  assign timeout = tick && (half_count + 8'd1 >= default_half); // [RULE_08]
  // Widened so that a saturated miss count still reaches the limit.
  assign miss_due = ({1'b0, miss_count} + 4'd1) >= {1'b0, miss_limit};
  assign ol_flip = tick && ((half_count + 8'd1 == ol_half) ||
    (half_count + 8'd1 >= {1'b0, OPEN_LOOP_PERIOD})); // [RULE_13]

  // Register writes; the report register is read only.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      actuator_config <= ACTUATOR_CONFIG_RESET;
      open_loop_fallback_config <= OPEN_LOOP_FALLBACK_CONFIG_RESET;
    end
    else if (REG_WR)
    begin
      if (REG_ADDR == ACTUATOR_CONFIG_ADDR)
        actuator_config <= REG_WDATA; // [RULE_01]
      if (REG_ADDR == OPEN_LOOP_FALLBACK_CONFIG_ADDR)
        open_loop_fallback_config <= REG_WDATA;
    end
  end

  // Registered read data; unmapped offsets read zero.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      REG_RDATA <= 8'h00;
    else
    begin
      case (REG_ADDR)
        ACTUATOR_CONFIG_ADDR: REG_RDATA <= actuator_config;
        OPEN_LOOP_FALLBACK_CONFIG_ADDR:
          REG_RDATA <= open_loop_fallback_config;
        RESONANCE_PERIOD_REPORT_ADDR:
          REG_RDATA <= resonance_period_report; // [RULE_05]
        default: REG_RDATA <= 8'h00;
      endcase
    end
  end

  // Waveform start edge detector.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      go_d <= 1'b0;
    else
      go_d <= GO;
  end

  // Next state of the tracker.
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (start && actuator_type_select)
          next_state = BEMF_VALID ? ST_TRACK : ST_FALLBACK;
      ST_TRACK:
        if (!GO)
          next_state = ST_IDLE;
        else if (auto_open_loop_enable && timeout && miss_due)
          next_state = ST_OPEN_LOOP; // [RULE_11] [RULE_12]
        else if (!BEMF_VALID)
          next_state = ST_FALLBACK; // [RULE_07]
      ST_FALLBACK:
        if (!GO)
          next_state = ST_IDLE;
        else if (auto_open_loop_enable && timeout && miss_due)
          next_state = ST_OPEN_LOOP; // [RULE_11] [RULE_12]
        else if (zc_hit)
          next_state = ST_TRACK; // [RULE_09]
      ST_OPEN_LOOP:
        if (!GO)
          next_state = ST_IDLE; // [RULE_10]
      default: next_state = ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // Half period timer: restarts at each zero cross or timeout, and at the end of each open-loop period.
  // Zero crosses are ignored once open loop has taken over.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      half_count <= 8'h00;
    else if (state == ST_IDLE ||
             (zc_hit && state != ST_OPEN_LOOP)) // [RULE_02] [RULE_10]
      half_count <= 8'h00;
    else if (state == ST_OPEN_LOOP)
    begin
      if (ol_flip && half_count + 8'd1 >= {1'b0, OPEN_LOOP_PERIOD})
        half_count <= 8'h00;
      else if (tick)
        half_count <= half_count + 8'd1;
    end
    else if (timeout)
      half_count <= 8'h00;
    else if (tick && half_count != 8'hff)
      half_count <= half_count + 8'd1;
  end

  // Unsynced cycle counter, cleared at each waveform start.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      miss_count <= 3'd0;
    else if (start || state == ST_IDLE) // [RULE_16]
      miss_count <= 3'd0;
    else if (zc_hit && state == ST_TRACK)
      miss_count <= 3'd0;
    else if (timeout && state != ST_OPEN_LOOP && miss_count != 3'd7)
      miss_count <= miss_count + 3'd1;
  end

  // Drive polarity: flips on zero crosses, timeouts and open-loop edges.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      polarity <= 1'b0;
    else if (state == ST_IDLE)
      polarity <= 1'b0;
    else if (state == ST_OPEN_LOOP)
    begin
      if (ol_flip)
        polarity <= ~polarity; // [RULE_13]
    end
    else if (zc_hit)
      polarity <= ~polarity; // [RULE_02] [RULE_03]
    else if (timeout)
      polarity <= ~polarity; // [RULE_07] [RULE_08]
  end

  // Period report: twice the half period captured at a tracked zero cross.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      resonance_period_report <= RESONANCE_PERIOD_RESET;
    else if (zc_hit && state == ST_TRACK)
    begin
      if (half_count[7])
        resonance_period_report <= 8'hff;
      else
        resonance_period_report <= {half_count[6:0], 1'b0}; // [RULE_05]
    end
  end

  // Trinary output stage and status flags.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
    begin
      DRIVE_POS <= 1'b0;
      DRIVE_NEG <= 1'b0;
      CLOSED_LOOP_ACTIVE <= 1'b0;
      SYNCED <= 1'b0;
    end
    else
    begin
      if (!actuator_type_select)
      begin
        DRIVE_POS <= GO; // [RULE_15]
        DRIVE_NEG <= 1'b0;
        CLOSED_LOOP_ACTIVE <= GO;
        SYNCED <= 1'b0;
      end
      else
      begin
        DRIVE_POS <= (state != ST_IDLE) && !polarity; // [RULE_15]
        DRIVE_NEG <= (state != ST_IDLE) && polarity;
        CLOSED_LOOP_ACTIVE <= (state == ST_TRACK) ||
          (state == ST_FALLBACK); // [RULE_14]
        SYNCED <= (state == ST_TRACK);
      end
    end
  end
endmodule

// >>> hdl/lrt_pkg.sv
// Package for the resonance tracking control block.
// Assumes a single 25 MHz clock domain and a byte-wide register port.
package lrt_pkg;
  // Register offsets on the byte register port.
  localparam logic [7:0] ACTUATOR_CONFIG_ADDR = 8'h1a;
  localparam logic [7:0] OPEN_LOOP_FALLBACK_CONFIG_ADDR = 8'h1f;
  localparam logic [7:0] RESONANCE_PERIOD_REPORT_ADDR = 8'h22;
  // Field positions.
  localparam int ACTUATOR_TYPE_SELECT_BIT = 7;
  localparam int AUTO_OPEN_LOOP_ENABLE_BIT = 4;
  localparam int OPEN_LOOP_FALLBACK_COUNT_LSB = 2;
  // Reset values.
  localparam logic [7:0] ACTUATOR_CONFIG_RESET = 8'h80;
  localparam logic [7:0] OPEN_LOOP_FALLBACK_CONFIG_RESET = 8'h00;
  localparam logic [7:0] RESONANCE_PERIOD_RESET = 8'h00;
  // Timing: one period unit and the clock it is counted in.
  localparam int CLK_PERIOD_NS = 40;
  localparam int PERIOD_UNIT_NS = 98490;
  localparam int PERIOD_UNIT_CYCLES = PERIOD_UNIT_NS / CLK_PERIOD_NS;
  localparam int TICK_CNT_W = 12;
  // Tracker states.
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_TRACK = 2'b01,
    ST_FALLBACK = 2'b10,
    ST_OPEN_LOOP = 2'b11
  } lrt_state_t;
endpackage

// >>> hdl/lrt_tick_if.sv
// Interface carrying the period unit tick between the tick divider and core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ns
interface lrt_tick_if;
  logic tick;
  modport source (output tick);
  modport sink (input tick);
endinterface

// >>> hdl/lrt_tick.sv
// Divider producing a one-cycle tick once per period unit.
// Assumes a synchronous active-low reset.
`timescale 1ns/1ns
module lrt_tick
  import lrt_pkg::*;
#(
  parameter int DIVIDE = PERIOD_UNIT_CYCLES
)
(
  input wire logic CLK,
  input wire logic RST_B,
  lrt_tick_if.source TICK
);
  import lrt_pkg::*;

  logic [TICK_CNT_W-1:0] count;

  // Counts clock cycles and wraps once per period unit.
  always_ff @(posedge CLK)
  begin
    if (!RST_B)
      count <= '0;
    else if (count == TICK_CNT_W'(DIVIDE - 1))
      count <= '0;
    else
      count <= count + 1'b1;
  end

  assign TICK.tick = (count == TICK_CNT_W'(DIVIDE - 1));
endmodule

// >>> verification/lrt_core_sva.sv
// Port checker for the resonance tracking core.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module lrt_core_sva
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic [7:0] REG_RDATA,
  input wire logic GO,
  input wire logic BEMF_VALID,
  input wire logic ZERO_CROSS,
  input wire logic DRIVE_POS,
  input wire logic DRIVE_NEG,
  input wire logic CLOSED_LOOP_ACTIVE,
  input wire logic SYNCED
);
  logic lra;
  logic auto;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // Shadow of the actuator type bit.
  always_ff @(posedge CLK)
    if (!RST_B) lra <= 1'b1;
    else if (REG_WR && REG_ADDR == 8'h1a) lra <= REG_WDATA[7];
  // Shadow of the auto open-loop enable bit.
  always_ff @(posedge CLK)
    if (!RST_B) auto <= 1'b0;
    else if (REG_WR && REG_ADDR == 8'h1f) auto <= REG_WDATA[4];
  a_drive_one_side: assert property (
    !(DRIVE_POS && DRIVE_NEG)) else $error("both sides driven");
  a_start_positive: assert property (
    lra && $rose(GO) ##1 GO |-> ##1 DRIVE_POS) else $error("no start");
  a_stop_off: assert property (
    $fell(GO) |-> ##2 (!DRIVE_POS && !DRIVE_NEG)) else $error("not off");
  a_zc_flip: assert property (
    (GO && SYNCED && BEMF_VALID && ZERO_CROSS && DRIVE_POS) ##1 GO[*2]
    |-> DRIVE_NEG) else $error("no flip on zero cross");
  a_ol_sticky: assert property (
    (GO && lra && $past(GO, 3) && !CLOSED_LOOP_ACTIVE) ##1 GO
    |-> !CLOSED_LOOP_ACTIVE && !SYNCED) else $error("left open loop");
  a_ol_only_auto: assert property (
    !auto && lra && GO && $past(GO, 3) |-> CLOSED_LOOP_ACTIVE)
    else $error("open loop without enable");
  a_unmapped_zero: assert property (
    $past(REG_ADDR) != 8'h1a && $past(REG_ADDR) != 8'h1f &&
    $past(REG_ADDR) != 8'h22 |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_fb_readback: assert property (
    REG_WR && REG_ADDR == 8'h1f ##1 (REG_ADDR == 8'h1f)[*2]
    |-> REG_RDATA[4:2] == $past(REG_WDATA[4:2], 2))
    else $error("fallback field lost");
endmodule

bind lrt_core lrt_core_sva u_lrt_core_sva (.CLK(CLK), .RST_B(RST_B),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
  .REG_RDATA(REG_RDATA), .GO(GO), .BEMF_VALID(BEMF_VALID),
  .ZERO_CROSS(ZERO_CROSS), .DRIVE_POS(DRIVE_POS), .DRIVE_NEG(DRIVE_NEG),
  .CLOSED_LOOP_ACTIVE(CLOSED_LOOP_ACTIVE), .SYNCED(SYNCED));

// >>> verification/lrt_actuator.sv
// Behavioural resonant actuator seen through its back-EMF comparator.
// Assumes the drive outputs of the core and the same clock.
`timescale 1ns/1ns
module lrt_actuator
(
  input wire logic CLK,
  input wire logic DRIVE_POS,
  input wire logic EN,
  input wire logic [15:0] HALF,
  output logic ZERO_CROSS = 1'b0,
  output logic BEMF_VALID
);
  logic [15:0] cnt = 16'h0000;
  logic last = 1'b0;
  // Back-EMF is usable only while the bench lets the mass move.
  assign BEMF_VALID = EN;
  // A zero cross follows each reversal, then repeats every half period.
  always @(posedge CLK)
  begin
    last <= DRIVE_POS;
    ZERO_CROSS <= EN && cnt >= HALF;
    if (DRIVE_POS != last || cnt >= HALF) cnt <= 16'h0000;
    else cnt <= cnt + 16'h0001;
  end
endmodule

// >>> verification/lrt_core_tb_top.sv
// Self-checking bench for the resonance tracking core.
// Assumes the internal unit divider at its full count.
`timescale 1ns/1ns
`define CK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module lrt_core_tb_top;
  localparam int U = lrt_pkg::PERIOD_UNIT_CYCLES;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdat = 8'h00;
  logic wr_s = 1'b0;
  logic go = 1'b0;
  logic en = 1'b0;
  logic [15:0] half = 16'h0064;
  logic [4:0] dt = 5'h1f;
  logic [1:0] det = 2'h0;
  logic [6:0] olp = 7'h04;
  logic [7:0] rdata;
  logic zc, bv, pos, neg, cla, syn;
  logic [7:0] q[$];
  logic [7:0] exp_r;
  logic [31:0] seed = 32'h7414988f;
  int n_errors = 0;
  int cmp_count = 0;
  event got;
  lrt_core u_lrt_core (.CLK(clk), .RST_B(rst_b), .REG_ADDR(addr),
    .REG_WDATA(wdat), .REG_WR(wr_s), .REG_RDATA(rdata), .GO(go),
    .BEMF_VALID(bv), .ZERO_CROSS(zc), .DRIVE_TIME(dt),
    .ZERO_CROSS_DETECT_TIME(det), .OPEN_LOOP_PERIOD(olp),
    .DRIVE_POS(pos), .DRIVE_NEG(neg), .CLOSED_LOOP_ACTIVE(cla),
    .SYNCED(syn));
  lrt_actuator u_lrt_actuator (.CLK(clk), .DRIVE_POS(pos), .EN(en),
    .HALF(half), .ZERO_CROSS(zc), .BEMF_VALID(bv));
  // Toggles the 25 MHz clock.
  always #20 clk = ~clk;
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdat = d;
    wr_s = 1'b1;
    @(negedge clk);
    wr_s = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    addr = a;
    q.push_back(e);
    cyc(2);
    -> got;
  endtask
  task automatic finish_test();
    $display("n_errors %0d cmp_count %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Compares each register read with the oldest queued note.
  always @(got)
  begin
    exp_r = q.pop_front();
    `CK("rdata", exp_r, rdata)
  end
  // Cuts a hung run short.
  initial
  begin
    #(40 * 70000);
    n_errors++;
    finish_test();
  end
  // Main sequence of scenarios.
  initial
  begin
    logic [7:0] a;
    int n;
    logic p0;
    cyc(3);
    rst_b = 1'b1;
    rd(8'h1a, 8'h80);
    rd(8'h1f, 8'h00);
    wr(8'h22, 8'hff);
    rd(8'h22, 8'h00);
    repeat (4)
    begin
      a = rnd();
      if (a != 8'h1a && a != 8'h1f && a != 8'h22)
      begin
        wr(a, rnd());
        rd(a, 8'h00);
      end
    end
    wr(8'h1f, 8'h14);
    rd(8'h1f, 8'h14);
    wr(8'h1f, 8'h00);
    wr(8'h1a, 8'h00);
    go = 1'b1;
    cyc(4);
    `CK("erm", 3'b101, {pos, neg, cla})
    go = 1'b0;
    cyc(4);
    wr(8'h1a, 8'h80);
    en = 1'b1;
    half = 16'(2 * U + U / 2);
    dt = 5'h18 | 5'(rnd() & 8'h07);
    det = 2'(rnd());
    go = 1'b1;
    cyc(3);
    `CK("lock", 2'b11, {pos, syn})
    cyc(2 * U + U / 2 + 10);
    `CK("track", 1'b1, neg)
    addr = 8'h22;
    cyc(2);
    `CK("period", 1'b1, rdata == 8'h04 || rdata == 8'h06)
    go = 1'b0;
    cyc(4);
    `CK("off", 2'b00, {pos, neg})
    en = 1'b0;
    half = 16'h0064;
    dt = 5'h03;
    det = 2'h0;
    go = 1'b1;
    cyc(3);
    `CK("fallback", 2'b01, {syn, cla})
    n = 0;
    while (neg !== 1'b1 && n < 3 * U)
    begin
      @(negedge clk);
      n++;
    end
    // Half period of 3 - 1 = 2 units; the first unit may be partial.
    `CK("fb_half", 1'b1, n >= U && n <= 2 * U)
    en = 1'b1;
    cyc(U);
    `CK("resync", 1'b1, syn)
    go = 1'b0;
    en = 1'b0;
    dt = 5'h02;
    wr(8'h1f, 8'h1c);
    go = 1'b1;
    cyc(2 * U);
    `CK("tolerate", 1'b1, cla)
    cyc(4 * U);
    `CK("open_loop", 2'b00, {cla, syn})
    en = 1'b1;
    cyc(U);
    `CK("no_resync", 1'b0, syn)
    // Times one open-loop half period while zero crosses keep arriving.
    p0 = pos;
    n = 0;
    while (pos === p0 && n < 3 * U)
    begin
      @(negedge clk);
      n++;
    end
    p0 = pos;
    n = 0;
    while (pos === p0 && n < 3 * U)
    begin
      @(negedge clk);
      n++;
    end
    `CK("ol_half", int'(olp) / 2 * U, n)
    go = 1'b0;
    en = 1'b0;
    cyc(4);
    go = 1'b1;
    cyc(2 * U);
    `CK("new_wave", 1'b1, cla)
    go = 1'b0;
    cyc(4);
    finish_test();
  end
endmodule
